/* core/wsfc_top.sv */
// Weight sample filter chain with AHB-Lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wsfc_top import wsfc_pkg::*; #(
   parameter int DW = WSFC_DW
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sample_valid,
   input wire logic signed [DW-1:0] sample_data,
   output logic filt_valid,
   output logic signed [DW-1:0] filt_data,
   output logic filt_cutout
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   wsfc_bus_t bus_state, next_bus_state;
   logic [7:0] addr_q, next_addr_q;
   logic wr_pend, next_wr_pend;
   logic [31:0] next_hrdata;
   wsfc_type_t ftype, next_ftype;
   logic [3:0] rate, next_rate;
   wsfc_sens_t sens, next_sens;
   logic [STAGE_LEN_W-1:0] stage_len [WSFC_STAGES];
   logic [STAGE_LEN_W-1:0] next_stage_len [WSFC_STAGES];
   logic [15:0] cut_thr, next_cut_thr;
   logic [7:0] cut_cnt, next_cut_cnt;
   logic cut_en, next_cut_en;
   logic [15:0] divsz, next_divsz;
   logic [10:0] athr, next_athr;
   logic [7:0] damp, next_damp;
   logic [31:0] rd_mux;
   logic take;
   logic unused_bits;

   // ----------------------------------------------------------------
   // Filter state
   // ----------------------------------------------------------------
   logic [7:0] cut_run, next_cut_run;
   logic [5:0] stable, next_stable;
   logic signed [DW-1:0] next_filt_data;
   logic next_filt_valid;
   logic next_filt_cutout;
   logic signed [DW:0] diff;
   logic [DW:0] mag;
   logic [31:0] cut_lim;
   logic cut_over;
   logic cut_fire;
   logic [2:0] ashift;
   logic [16:0] damp_k;
   logic st_restart;
   logic st_in_valid [WSFC_STAGES];
   logic signed [DW-1:0] st_in_data [WSFC_STAGES];
   logic st_out_valid [WSFC_STAGES];
   logic signed [DW-1:0] st_out_data [WSFC_STAGES];

   assign unused_bits = ^{haddr[31:8], haddr[1:0], hsize, htrans[0]};

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      case ({addr_q[7:2], 2'b00})
         OFS_CTRL: begin
            rd_mux[CTRL_TYPE_LSB +: 2] = ftype;
            rd_mux[CTRL_RATE_LSB +: 4] = rate;
            rd_mux[CTRL_SENS_LSB +: 2] = sens;
         end
         OFS_STAGE: begin
            for (int i = 0; i < WSFC_STAGES; i++) begin
               rd_mux[i*STAGE_LEN_W +: STAGE_LEN_W] = stage_len[i];
            end
         end
         OFS_CUTOUT: begin
            rd_mux[CUT_THR_LSB +: 16] = cut_thr;
            rd_mux[CUT_CNT_LSB +: 8] = cut_cnt;
            rd_mux[CUT_EN_BIT] = cut_en;
         end
         OFS_DIVSZ: rd_mux[15:0] = divsz;
         OFS_ATHR: rd_mux[10:0] = athr;
         OFS_DAMP: rd_mux[7:0] = damp;
         OFS_OUT: rd_mux = 32'($signed(filt_data));
         OFS_STAT: begin
            rd_mux[STAT_RUN_LSB +: 8] = cut_run;
            rd_mux[STAT_STABLE_LSB +: 6] = stable;
            rd_mux[STAT_TYPE_LSB +: 2] = ftype;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      take = hsel && htrans[1] && hready;
      next_bus_state = bus_state;
      next_addr_q = addr_q;
      next_wr_pend = 1'b0;
      next_hrdata = hrdata;
      next_ftype = ftype;
      next_rate = rate;
      next_sens = sens;
      next_stage_len = stage_len;
      next_cut_thr = cut_thr;
      next_cut_cnt = cut_cnt;
      next_cut_en = cut_en;
      next_divsz = divsz;
      next_athr = athr;
      next_damp = damp;
      if (wr_pend) begin
         case ({addr_q[7:2], 2'b00})
            OFS_CTRL: begin
               // Filter type and reading rate, see RULE1 and RULE2
               next_ftype = wsfc_type_t'(hwdata[CTRL_TYPE_LSB +: 2]);
               next_rate = hwdata[CTRL_RATE_LSB +: 4];
               next_sens = wsfc_sens_t'(hwdata[CTRL_SENS_LSB +: 2]);
            end
            OFS_STAGE: begin
               for (int i = 0; i < WSFC_STAGES; i++) begin
                  next_stage_len[i] = hwdata[i*STAGE_LEN_W +: STAGE_LEN_W];
               end
            end
            OFS_CUTOUT: begin
               next_cut_thr = hwdata[CUT_THR_LSB +: 16];
               next_cut_cnt = hwdata[CUT_CNT_LSB +: 8];
               next_cut_en = hwdata[CUT_EN_BIT];
            end
            OFS_DIVSZ: next_divsz = hwdata[15:0];
            OFS_ATHR: begin
               // Threshold clamps to its range, see RULE11
               next_athr = (hwdata[31:0] > 32'(ATHR_MAX)) ? ATHR_MAX
                                                         : hwdata[10:0];
            end
            OFS_DAMP: next_damp = hwdata[7:0];
            default: next_damp = damp;
         endcase
      end
      case (bus_state)
         WSFC_BUS_IDLE: next_bus_state = WSFC_BUS_IDLE;
         WSFC_BUS_WAIT: begin
            next_hrdata = rd_mux;
            next_bus_state = WSFC_BUS_DATA;
         end
         WSFC_BUS_DATA: next_bus_state = WSFC_BUS_IDLE;
         default: next_bus_state = WSFC_BUS_IDLE;
      endcase
      if (take) begin
         next_addr_q = haddr[7:0];
         if (hwrite) begin
            next_wr_pend = 1'b1;
         end else begin
            next_bus_state = WSFC_BUS_WAIT;
         end
      end
   end

   assign hreadyout = (bus_state != WSFC_BUS_WAIT);
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= WSFC_BUS_IDLE;
         addr_q <= 8'h00;
         wr_pend <= 1'b0;
         hrdata <= 32'h0000_0000;
         ftype <= wsfc_type_t'(RST_TYPE);
         rate <= RST_RATE;
         sens <= wsfc_sens_t'(RST_SENS);
         for (int i = 0; i < WSFC_STAGES; i++) begin
            stage_len[i] <= RST_STAGE_LEN;
         end
         cut_thr <= RST_CUT_THR;
         cut_cnt <= RST_CUT_CNT;
         cut_en <= RST_CUT_EN;
         divsz <= RST_DIVSZ;
         athr <= RST_ATHR;
         damp <= RST_DAMP;
      end else begin
         bus_state <= next_bus_state;
         addr_q <= next_addr_q;
         wr_pend <= next_wr_pend;
         hrdata <= next_hrdata;
         ftype <= next_ftype;
         rate <= next_rate;
         sens <= next_sens;
         stage_len <= next_stage_len;
         cut_thr <= next_cut_thr;
         cut_cnt <= next_cut_cnt;
         cut_en <= next_cut_en;
         divsz <= next_divsz;
         athr <= next_athr;
         damp <= next_damp;
      end
   end

   // ----------------------------------------------------------------
   // Rolling average cascade
   // ----------------------------------------------------------------
   // Stages restart on cutout and track raw input in other modes
   assign st_restart = sample_valid && (cut_fire || ftype != WSFC_ROLL);

   for (genvar g = 0; g < WSFC_STAGES; g++) begin : g_stage
      if (g == 0) begin : g_first
         assign st_in_valid[g] = sample_valid && ftype == WSFC_ROLL;
         assign st_in_data[g] = sample_data;
      end else begin : g_next
         assign st_in_valid[g] = st_out_valid[g-1]; // see RULE5
         assign st_in_data[g] = st_out_data[g-1];
      end
      wsfc_avg_stage #(
         .DW(DW),
         .LW(WSFC_LW),
         .DEPTH(WSFC_DEPTH)
      ) u_stage (
         .hclk(hclk),
         .hresetn(hresetn),
         .len(WSFC_LW'({1'b0, stage_len[g]} + 1'b1)),
         .in_valid(st_in_valid[g]),
         .in_data(st_in_data[g]),
         .restart(st_restart),
         .restart_data(sample_data),
         .out_valid(st_out_valid[g]),
         .out_data(st_out_data[g])
      );
   end

   // ----------------------------------------------------------------
   // Mode selection and output
   // ----------------------------------------------------------------
   always_comb begin
      diff = (DW+1)'(sample_data) - (DW+1)'(filt_data);
      mag = diff[DW] ? (DW+1)'(-diff) : diff;
      // Threshold in display divisions, see RULE8
      cut_lim = 32'(cut_thr) * 32'(divsz);
      cut_over = cut_en && (32'(mag) > cut_lim);
      // Fires once the run of out-of-band readings is long enough
      cut_fire = sample_valid && ftype == WSFC_ROLL && cut_over
                 && (9'(cut_run) + 9'd1 >= 9'(cut_cnt)); // see RULE7
      case (sens)
         WSFC_HEAVY: ashift = SHIFT_HEAVY; // see RULE10
         WSFC_MEDIUM: ashift = SHIFT_MEDIUM;
         WSFC_LIGHT: ashift = SHIFT_LIGHT;
         default: ashift = SHIFT_MEDIUM;
      endcase
      // Stable time deepens the weighting, see RULE9
      ashift = 3'(ashift + 3'(stable >> STABLE_STEP_LOG));
      // Damping length in readings from tenths and rate, see RULE15
      damp_k = 17'((25'(damp) * 25'(wsfc_rate_q(rate))) / 25'(DAMP_DIV));
      next_filt_data = filt_data;
      next_filt_valid = 1'b0;
      next_filt_cutout = 1'b0;
      next_cut_run = cut_run;
      next_stable = stable;
      case (ftype)
         WSFC_RAW: begin
            next_cut_run = 8'h00;
            if (sample_valid) begin
               next_filt_data = sample_data; // see RULE1
               next_filt_valid = 1'b1;
            end
         end
         WSFC_ROLL: begin
            if (cut_fire) begin
               next_filt_data = sample_data; // see RULE6
               next_filt_valid = 1'b1;
               next_filt_cutout = 1'b1;
               next_cut_run = 8'h00;
            end else begin
               if (sample_valid) begin
                  next_cut_run = cut_over ? 8'(cut_run + 1'b1) : 8'h00;
               end
               if (st_out_valid[WSFC_STAGES-1]) begin
                  next_filt_data = st_out_data[WSFC_STAGES-1];
                  next_filt_valid = 1'b1;
               end
            end
         end
         WSFC_ADAPT: begin
            next_cut_run = 8'h00;
            if (sample_valid) begin
               next_filt_valid = 1'b1;
               if (athr == 11'd0 || mag > (DW+1)'(athr)) begin
                  // Off, or a large step resets the filter, see RULE12 and RULE14
                  next_filt_data = sample_data;
                  next_stable = 6'd0;
               end else begin
                  // Equal difference still averages, see RULE13 and RULE17
                  next_filt_data = DW'(filt_data + DW'(diff >>> ashift));
                  next_stable = (stable < STABLE_MAX) ? 6'(stable + 1'b1)
                                                      : stable;
               end
            end
         end
         WSFC_DAMP: begin
            next_cut_run = 8'h00;
            if (sample_valid) begin
               next_filt_valid = 1'b1;
               if (damp_k <= 17'd1) begin
                  next_filt_data = sample_data;
               end else begin
                  // Fixed fraction of remaining gap, see RULE16
                  next_filt_data = DW'(filt_data
                     + DW'(diff / $signed({1'b0, damp_k})));
               end
            end
         end
         default: next_filt_data = filt_data;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cut_run <= 8'h00;
         stable <= 6'd0;
         filt_data <= '0;
         filt_valid <= 1'b0;
         filt_cutout <= 1'b0;
      end else begin
         cut_run <= next_cut_run;
         stable <= next_stable;
         filt_data <= next_filt_data;
         filt_valid <= next_filt_valid;
         filt_cutout <= next_filt_cutout;
      end
   end
endmodule
`default_nettype wire

/* core/wsfc_pkg.sv */
// Constants and types of the weight sample filter chain
// Operation
// RULE1: Filter type selects rolling average, adaptive, damping or raw pass-through.
// RULE2: Readings arrive at a selectable rate; every filter works per reading.
// RULE3: Each of three rolling stages averages 1 to 256 readings.
// RULE4: Stage length one is transparent; all three at one means no filtering.
// RULE5: Each stage's running average feeds the next stage.
// RULE6: On cutout, output jumps to newest reading and averaging restarts there.
// RULE7: Cutout needs a set count of consecutive readings beyond the threshold.
// RULE8: Cutout threshold is in display divisions; NONE disables the cutout.
// RULE9: Adaptive average weights new readings less the longer changes stay small.
// RULE10: Heavy, medium, light set newest reading weight; heavy is most stable.
// RULE11: Adaptive threshold is a weight value from 0 to 2000.
// RULE12: Difference above adaptive threshold resets output and stability history.
// RULE13: Small difference gives average weighted by stable time and sensitivity.
// RULE14: Adaptive threshold zero turns the adaptive filter off.
// RULE15: Damping value in tenths of a second sets the settling time.
// RULE16: Damped output approaches the final weight asymptotically.
// RULE17: Difference equal to the adaptive threshold takes the averaging path.
// RULE18: Each stage updates per input reading with a sliding window.
package wsfc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int WSFC_DW = 24;
   localparam int WSFC_LW = 9;
   localparam int WSFC_DEPTH = 256;
   localparam int WSFC_STAGES = 3;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAGE = 8'h04;
   localparam logic [7:0] OFS_CUTOUT = 8'h08;
   localparam logic [7:0] OFS_DIVSZ = 8'h0C;
   localparam logic [7:0] OFS_ATHR = 8'h10;
   localparam logic [7:0] OFS_DAMP = 8'h14;
   localparam logic [7:0] OFS_OUT = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_TYPE_LSB = 0;
   localparam int CTRL_RATE_LSB = 2;
   localparam int CTRL_SENS_LSB = 6;
   localparam int STAGE_LEN_W = 8;
   localparam int CUT_THR_LSB = 0;
   localparam int CUT_CNT_LSB = 16;
   localparam int CUT_EN_BIT = 24;
   localparam int STAT_RUN_LSB = 0;
   localparam int STAT_STABLE_LSB = 8;
   localparam int STAT_TYPE_LSB = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] RST_TYPE = 2'h0;
   localparam logic [3:0] RST_RATE = 4'h0;
   localparam logic [1:0] RST_SENS = 2'h1;
   localparam logic [7:0] RST_STAGE_LEN = 8'h00;
   localparam logic [15:0] RST_CUT_THR = 16'h0000;
   localparam logic [7:0] RST_CUT_CNT = 8'h01;
   localparam logic RST_CUT_EN = 1'b0;
   localparam logic [15:0] RST_DIVSZ = 16'h0001;
   localparam logic [10:0] RST_ATHR = 11'h000;
   localparam logic [7:0] RST_DAMP = 8'h00;

   // ----------------------------------------------------------------
   // Limits and timing
   // ----------------------------------------------------------------
   localparam logic [10:0] ATHR_MAX = 11'd2000;
   localparam logic [5:0] STABLE_MAX = 6'd32;
   localparam int STABLE_STEP_LOG = 3;
   localparam int DAMP_TENTHS_PER_S = 10;
   localparam int RATE_Q_PER_HZ = 4;
   localparam logic [16:0] DAMP_DIV = 17'(DAMP_TENTHS_PER_S * RATE_Q_PER_HZ);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WSFC_RAW = 2'b00,
      WSFC_ROLL = 2'b01,
      WSFC_ADAPT = 2'b10,
      WSFC_DAMP = 2'b11
   } wsfc_type_t;

   typedef enum logic [1:0] {
      WSFC_HEAVY = 2'b00,
      WSFC_MEDIUM = 2'b01,
      WSFC_LIGHT = 2'b10
   } wsfc_sens_t;

   typedef enum logic [1:0] {
      WSFC_BUS_IDLE = 2'b00,
      WSFC_BUS_WAIT = 2'b01,
      WSFC_BUS_DATA = 2'b10
   } wsfc_bus_t;

   localparam logic [2:0] SHIFT_HEAVY = 3'd3;
   localparam logic [2:0] SHIFT_MEDIUM = 3'd2;
   localparam logic [2:0] SHIFT_LIGHT = 3'd1;

   // Reading rate in quarter hertz per rate code
   function automatic logic [8:0] wsfc_rate_q(input logic [3:0] code);
      case (code)
         4'h0: wsfc_rate_q = 9'd25;
         4'h1: wsfc_rate_q = 9'd30;
         4'h2: wsfc_rate_q = 9'd50;
         4'h3: wsfc_rate_q = 9'd60;
         4'h4: wsfc_rate_q = 9'd100;
         4'h5: wsfc_rate_q = 9'd120;
         4'h6: wsfc_rate_q = 9'd200;
         4'h7: wsfc_rate_q = 9'd240;
         4'h8: wsfc_rate_q = 9'd480;
         default: wsfc_rate_q = 9'd25;
      endcase
   endfunction

endpackage

/* core/wsfc_avg_stage.sv */
// One sliding-window rolling average stage
`timescale 1ns/1ps
`default_nettype none
module wsfc_avg_stage import wsfc_pkg::*; #(
   parameter int DW = WSFC_DW,
   parameter int LW = WSFC_LW,
   parameter int DEPTH = WSFC_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [LW-1:0] len,
   input wire logic in_valid,
   input wire logic signed [DW-1:0] in_data,
   input wire logic restart,
   input wire logic signed [DW-1:0] restart_data,
   output logic out_valid,
   output logic signed [DW-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int SW = DW + LW + 1;

   logic signed [DW-1:0] window [DEPTH];
   logic [AW-1:0] ptr, next_ptr;
   logic [LW-1:0] filled, next_filled;
   logic [LW-1:0] len_q, next_len_q;
   logic signed [SW-1:0] sum, next_sum;
   logic signed [DW-1:0] fill_val, next_fill_val;
   logic signed [DW-1:0] next_out_data;
   logic next_out_valid;
   logic signed [DW-1:0] oldest;
   logic signed [DW-1:0] restart_val;
   logic signed [SW-1:0] sum_upd;
   logic do_restart;

   always_comb begin
      do_restart = restart || (len != len_q);
      restart_val = restart ? restart_data : out_data;
      // Slots not yet written since a restart count as the restart value
      oldest = (filled < len_q) ? fill_val : window[ptr];
      sum_upd = sum + SW'(in_data) - SW'(oldest); // see RULE18
      next_ptr = ptr;
      next_filled = filled;
      next_len_q = len_q;
      next_sum = sum;
      next_fill_val = fill_val;
      next_out_data = out_data;
      next_out_valid = 1'b0;
      if (do_restart) begin
         // Window restarts as if full of the restart value, see RULE6
         next_len_q = len;
         next_sum = SW'(restart_val * $signed({1'b0, len}));
         next_fill_val = restart_val;
         next_filled = '0;
         next_ptr = '0;
         next_out_data = restart_val;
      end else if (in_valid) begin
         next_sum = sum_upd;
         next_ptr = ({1'b0, ptr} == LW'(len_q - 1'b1)) ? '0 : AW'(ptr + 1'b1);
         next_filled = (filled < len_q) ? LW'(filled + 1'b1) : filled;
         // Average over the configured length, see RULE3 and RULE4
         next_out_data = DW'(sum_upd / $signed({1'b0, len_q}));
         next_out_valid = 1'b1;
      end
   end

   always_ff @(posedge hclk) begin
      if (in_valid && !do_restart) begin
         window[ptr] <= in_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr <= '0;
         filled <= '0;
         len_q <= LW'(1);
         sum <= '0;
         fill_val <= '0;
         out_data <= '0;
         out_valid <= 1'b0;
      end else begin
         ptr <= next_ptr;
         filled <= next_filled;
         len_q <= next_len_q;
         sum <= next_sum;
         fill_val <= next_fill_val;
         out_data <= next_out_data;
         out_valid <= next_out_valid;
      end
   end
endmodule
`default_nettype wire

/* testbench/wsfc_top_sva.sv */
// Port checker for the filter chain
`timescale 1ns/1ps
`default_nettype none
module wsfc_top_sva import wsfc_pkg::*; #(
   parameter int DW = WSFC_DW
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sample_valid,
   input wire logic filt_valid,
   input wire logic signed [DW-1:0] filt_data,
   input wire logic filt_cutout
);
   // --------
   // Properties
   // --------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take; hsel && htrans[1] && hready; endsequence
   sequence s_rd; s_take ##0 !hwrite; endsequence
   sequence s_wait; !hreadyout ##1 hreadyout; endsequence
   property p_okay; !hresp; endproperty
   property p_rd; s_rd |=> s_wait; endproperty
   property p_wr; s_take ##0 hwrite |=> hreadyout; endproperty
   property p_one; !hreadyout |=> hreadyout; endproperty
   property p_ans; sample_valid |-> ##[1:4] filt_valid; endproperty
   property p_src;
      filt_valid |-> $past(sample_valid) || $past(sample_valid, 4);
   endproperty
   property p_pulse; filt_valid |=> !filt_valid; endproperty
   property p_cut; filt_cutout |-> filt_valid && $past(sample_valid); endproperty
   property p_hold; !filt_valid |-> $stable(filt_data); endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rd: assert property (p_rd) else $error("read wait wrong");
   a_wr: assert property (p_wr) else $error("write waited");
   a_one: assert property (p_one) else $error("wait too long");
   a_ans: assert property (p_ans) else $error("no output");
   a_src: assert property (p_src) else $error("stray output");
   a_pulse: assert property (p_pulse) else $error("long pulse");
   a_cut: assert property (p_cut) else $error("bad cutout");
   a_hold: assert property (p_hold) else $error("output moved");
endmodule
bind wsfc_top wsfc_top_sva #(.DW(DW)) i_sva (.hclk, .hresetn, .hsel,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .sample_valid,
   .filt_valid, .filt_data, .filt_cutout);
`default_nettype wire

/* testbench/wsfc_adc_model.sv */
// Converter model handing readings to the filter chain
`timescale 1ns/1ps
`default_nettype none
module wsfc_adc_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic go,
   input wire logic signed [23:0] val,
   output logic sample_valid,
   output logic signed [23:0] sample_data
);
   // --------
   // Reading output
   // --------
   logic next_valid;
   logic signed [23:0] next_data;
   always_comb begin
      next_valid = go; // One reading per conversion
      next_data = go ? val : ~sample_data;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_valid <= 1'b0;
         sample_data <= 24'h00_0000;
      end else begin
         sample_valid <= next_valid;
         sample_data <= next_data;
      end
   end
endmodule
`default_nettype wire

/* testbench/test_weight_sample_filter_chain.sv */
// Testbench of the filter chain
`timescale 1ns/1ps
`default_nettype none
module test_weight_sample_filter_chain import wsfc_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go, cut;
   logic sample_valid, filt_valid, filt_cutout;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic signed [23:0] sample_data, filt_data, val;
   int num_errors, comparisons;
   assign hready = hreadyout;
   wsfc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sample_valid,
      .sample_data, .filt_valid, .filt_data, .filt_cutout);
   wsfc_adc_model i_adc (.hclk, .hresetn, .go, .val, .sample_valid,
      .sample_data);
   // --------
   // Tasks
   // --------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, rd, e);
   endtask
   task automatic smp(input logic [23:0] v, input logic [31:0] e);
      int n;
      go <= 1'b1;
      val <= v;
      @(posedge hclk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (filt_valid !== 1'b1 && n < 10);
      if (filt_valid !== 1'b1) begin
         num_errors++;
         final_report();
      end
      cut = filt_cutout;
      repeat (2) @(posedge hclk);
      chk("filt", {8'h00, filt_data}, e);
   endtask
   // --------
   // Sequence
   // --------
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, go} = 4'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      val = 24'h00_0000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("ctrl", OFS_CTRL, 32'h0000_0040);
      rchk("cutout", OFS_CUTOUT, 32'h0001_0000);
      rchk("divsz", OFS_DIVSZ, 32'h0000_0001);
      rchk("unmapped", 8'h20, 32'h0000_0000);
      bus(1'b1, OFS_ATHR, 32'h0000_0BB8);
      rchk("athr", OFS_ATHR, 32'h0000_07D0);
      $display("register test done");
      smp(24'h00_0064, 32'h0000_0064);
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      smp(24'h00_00C8, 32'h0000_00C8);
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
      bus(1'b1, OFS_STAGE, 32'h0000_0101);
      smp(24'h00_0000, 32'h0000_0000);
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      smp(24'h00_0190, 32'h0000_0064);
      smp(24'h00_0190, 32'h0000_012C);
      bus(1'b1, OFS_CUTOUT, 32'h0102_0001);
      smp(24'h00_03E8, 32'h0000_0226);
      chk("cut0", {31'h0, cut}, 32'h0000_0000);
      smp(24'h00_03E8, 32'h0000_03E8);
      chk("cut1", {31'h0, cut}, 32'h0000_0001);
      $display("rolling test done");
      bus(1'b1, OFS_ATHR, 32'h0000_000A);
      bus(1'b1, OFS_CTRL, 32'h0000_0082);
      smp(24'h00_044C, 32'h0000_044C);
      smp(24'h00_0456, 32'h0000_0451);
      bus(1'b1, OFS_ATHR, 32'h0000_0000);
      smp(24'h00_04B0, 32'h0000_04B0);
      bus(1'b1, OFS_ATHR, 32'h0000_000A);
      bus(1'b1, OFS_CTRL, 32'h0000_0002);
      smp(24'h00_04B8, 32'h0000_04B1);
      bus(1'b1, OFS_CTRL, 32'h0000_0042);
      smp(24'h00_04B9, 32'h0000_04B3);
      rchk("stat", OFS_STAT, 32'h0002_0200);
      $display("adaptive test done");
      bus(1'b1, OFS_CTRL, 32'h0000_0003);
      bus(1'b1, OFS_DAMP, 32'h0000_000A);
      smp(24'h00_0709, 32'h0000_0516);
      smp(24'h00_0709, 32'h0000_0569);
      rchk("out", OFS_OUT, 32'h0000_0569);
      bus(1'b1, OFS_CTRL, 32'h0000_0023);
      smp(24'h00_0709, 32'h0000_056C);
      $display("damping test done");
      final_report();
   end
endmodule
`default_nettype wire
